// file: src/mxdec_pkg.sv
// shared constants and types for the bus matrix address decoder
package mxdec_pkg;
   // ==========================================================
   // matrix shape
   localparam int NUM_MST   = 5;
   localparam int NUM_SLV   = 5;
   localparam int ADDR_W    = 32;
   // ==========================================================
   // first level: 256 MB areas on addr[31:28]
   localparam logic [3:0] AREA_INT    = 4'h0;
   localparam logic [3:0] AREA_EXT_LO = 4'h1;
   localparam logic [3:0] AREA_EXT_HI = 4'h8;
   localparam logic [3:0] AREA_PERIPH = 4'hF;
   // ==========================================================
   // second level: 1 MB regions on addr[27:20] inside area 0
   localparam logic [7:0] REG_BOOT  = 8'h00;
   localparam logic [7:0] REG_INSTR_TIGHT_MEM  = 8'h01;
   localparam logic [7:0] REG_DATA_TIGHT_MEM  = 8'h02;
   localparam logic [7:0] REG_SRAMC = 8'h03;
   localparam logic [7:0] REG_ROM   = 8'h04;
   localparam logic [7:0] REG_USBH  = 8'h05;
   localparam logic [7:0] REG_LCD   = 8'h06;
   // ==========================================================
   // slave numbers
   localparam logic [2:0] SLV_SRAM   = 3'h0;
   localparam logic [2:0] SLV_ROM    = 3'h1;
   localparam logic [2:0] SLV_DISP   = 3'h2;
   localparam logic [2:0] SLV_EXT    = 3'h3;
   localparam logic [2:0] SLV_PERIPH = 3'h4;
   localparam logic [2:0] SLV_NONE   = 3'h7;
   // ==========================================================
   // sram split: ten 16 KB blocks, two always in sram c
   localparam int         BLK_OFF_W   = 14;
   localparam logic [3:0] NUM_BLK     = 4'hA;
   localparam logic [3:0] PERM_C_BLK  = 4'h2;
   localparam logic [3:0] INSTR_TIGHT_MEM_TOP    = 4'h3;
   localparam logic [3:0] DATA_TIGHT_MEM_TOP    = 4'h7;
   localparam int         ROM_ADDR_W  = 15;
   localparam logic [1:0] TCM_RESET   = 2'h0;
   // ==========================================================
   // timing
   localparam logic [1:0] BOOT_SAMPLE = 2'h2;
   typedef enum logic [1:0] {
      MXDEC_IDLE = 2'b00,
      MXDEC_ERR1 = 2'b01,
      MXDEC_ERR2 = 2'b11
   } mxdec_err_t;
   // size code 0,1,2,3 means 0,16,32,64 KB
   function automatic logic [2:0] tcm_blocks(input logic [1:0] code);
      tcm_blocks = (code == 2'h3) ? 3'h4 : {1'b0, code};
   endfunction
endpackage

// file: src/mxdec_cfg_if.sv
// live split and alias settings handed to every master decoder
`timescale 1ns/10ps
`default_nettype none
interface mxdec_cfg_if;
   logic [2:0] instr_tight_mem_blk;
   logic [2:0] data_tight_mem_blk;
   logic [1:0] remap;
   logic       boot;
   modport ctrl(output instr_tight_mem_blk, output data_tight_mem_blk, output remap, output boot);
   modport dec(input instr_tight_mem_blk, input data_tight_mem_blk, input remap, input boot);
endinterface
`default_nettype wire

// file: src/mxdec_master.sv
// per-master two-level address decoder
`timescale 1ns/10ps
`default_nettype none
module mxdec_master import mxdec_pkg::*; #(
   parameter int MST = 0
) (
   // settings
   mxdec_cfg_if.dec          cfg,
   // request address
   input  wire logic [31:0]  addr_i,
   // decode result
   output logic [2:0]        slave_o,
   output logic [2:0]        cs_o,
   output logic [3:0]        blk_o,
   output logic              abort_o
);
   // ==========================================================
   // sram c: k-th highest block left free by the two tcms
   function automatic logic [3:0] c_block(input logic [3:0] idx, input logic [2:0] ni, input logic [2:0] nd);
      logic [3:0] r;
      logic [3:0] cnt;
      logic       used;
      r   = 4'h0;
      cnt = 4'h0;
      for (int b = 9; b >= 0; b--) begin
         used = (b <= 3 && b >= 4 - int'(ni)) || (b >= 4 && b <= 7 && b >= 8 - int'(nd));
         if (!used) begin
            if (cnt == idx) r = 4'(b);
            cnt = cnt + 4'h1;
         end
      end
      return r;
   endfunction

   logic [3:0] area;
   logic [7:0] region;
   logic [5:0] bidx;
   logic [3:0] nc;
   assign area   = addr_i[31:28];
   assign region = addr_i[27:20];
   assign bidx   = addr_i[19:14];
   // blocks 8 and 9 are never taken by a tcm
   assign nc     = NUM_BLK - {1'b0, cfg.instr_tight_mem_blk} - {1'b0, cfg.data_tight_mem_blk};

   // ==========================================================
   // decode
   always_comb begin
      slave_o = SLV_NONE;
      cs_o    = 3'h0;
      blk_o   = 4'h0;
      abort_o = 1'b1;
      if (area == AREA_INT) begin
         case (region)
            REG_BOOT: begin
               if (MST < 2 && cfg.remap[MST % 2]) begin
                  if (bidx < {2'h0, nc}) begin
                     slave_o = SLV_SRAM;
                     blk_o   = c_block(bidx[3:0], cfg.instr_tight_mem_blk, cfg.data_tight_mem_blk);
                     abort_o = 1'b0;
                  end
               end else if (cfg.boot) begin
                  if (addr_i[19:ROM_ADDR_W] == '0) begin
                     slave_o = SLV_ROM;
                     abort_o = 1'b0;
                  end
               end else begin
                  slave_o = SLV_EXT;
                  abort_o = 1'b0;
               end
            end
            REG_INSTR_TIGHT_MEM: begin
               if (bidx < {3'h0, cfg.instr_tight_mem_blk}) begin
                  slave_o = SLV_SRAM;
                  blk_o   = INSTR_TIGHT_MEM_TOP - bidx[3:0];
                  abort_o = 1'b0;
               end
            end
            REG_DATA_TIGHT_MEM: begin
               if (bidx < {3'h0, cfg.data_tight_mem_blk}) begin
                  slave_o = SLV_SRAM;
                  blk_o   = DATA_TIGHT_MEM_TOP - bidx[3:0];
                  abort_o = 1'b0;
               end
            end
            REG_SRAMC: begin
               if (bidx < {2'h0, nc}) begin
                  slave_o = SLV_SRAM;
                  blk_o   = c_block(bidx[3:0], cfg.instr_tight_mem_blk, cfg.data_tight_mem_blk);
                  abort_o = 1'b0;
               end
            end
            REG_ROM: begin
               if (addr_i[19:ROM_ADDR_W] == '0) begin
                  slave_o = SLV_ROM;
                  abort_o = 1'b0;
               end
            end
            REG_USBH, REG_LCD: begin
               slave_o = SLV_DISP;
               abort_o = 1'b0;
            end
            default: begin
               slave_o = SLV_NONE;
            end
         endcase
      end else if (area >= AREA_EXT_LO && area <= AREA_EXT_HI) begin
         slave_o = SLV_EXT;
         cs_o    = 3'(area - AREA_EXT_LO);
         abort_o = 1'b0;
      end else if (area == AREA_PERIPH) begin
         slave_o = SLV_PERIPH;
         abort_o = 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: src/mxdec_top.sv
// bus matrix address decode, per-slave arbitration and sram split
`timescale 1ns/10ps
`default_nettype none
module mxdec_top import mxdec_pkg::*; (
   // clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rstn_i,
   // boot strap pin
   input  wire logic                        boot_select_i,
   // split, alias and arbitration settings
   input  wire logic [1:0]                  instr_tight_mem_size_i,
   input  wire logic [1:0]                  data_tight_mem_size_i,
   input  wire logic [1:0]                  remap_bit_i,
   input  wire logic [NUM_SLV-1:0]          arb_fixed_i,
   // master requests
   input  wire logic [NUM_MST-1:0]          req_i,
   input  wire logic [NUM_MST-1:0][31:0]    addr_i,
   // master answers
   output logic [NUM_MST-1:0]               ack_o,
   output logic [NUM_MST-1:0]               err_o,
   output logic [NUM_MST-1:0][2:0]          slave_o,
   // slave side
   output logic [NUM_SLV-1:0][NUM_MST-1:0]  grant_o,
   output logic [7:0]                       ext_cs_o,
   output logic [3:0]                       sram_blk_o,
   output logic [BLK_OFF_W-1:0]             sram_off_o,
   // status
   output logic                             boot_sel_o,
   output logic [3:0]                       sramc_blk_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   // ==========================================================
   // boot strap capture
   logic       bs_meta_reg;
   logic       bs_sync_reg;
   logic       boot_reg;
   logic       boot_done_reg;
   logic [1:0] boot_cnt_reg;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         bs_meta_reg <= 1'b0;
         bs_sync_reg <= 1'b0;
      end else begin
         bs_meta_reg <= boot_select_i;
         bs_sync_reg <= bs_meta_reg;
      end
   end
   // pin can not load an async-reset flop, so take it once the sync has settled
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         boot_cnt_reg  <= 2'h0;
         boot_done_reg <= 1'b0;
         boot_reg      <= 1'b0;
      end else if (!boot_done_reg) begin
         boot_cnt_reg <= boot_cnt_reg + 2'h1;
         if (boot_cnt_reg == BOOT_SAMPLE) begin
            boot_reg      <= bs_sync_reg;
            boot_done_reg <= 1'b1;
         end
      end
   end
   assign boot_sel_o = boot_reg;

   // ==========================================================
   // live settings, loaded only with the matrix quiet
   mxdec_err_t [NUM_MST-1:0] st_reg;
   logic [2:0]               instr_tight_mem_reg;
   logic [2:0]               data_tight_mem_reg;
   logic [1:0]               remap_reg;
   logic [3:0]               sramc_reg;
   logic                     busy;
   // steady traffic can hold off a settings change for good
   always_comb begin
      busy = |req_i;
      for (int m = 0; m < NUM_MST; m++) begin
         if (st_reg[m] != MXDEC_IDLE) busy = 1'b1;
      end
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         instr_tight_mem_reg  <= tcm_blocks(TCM_RESET);
         data_tight_mem_reg  <= tcm_blocks(TCM_RESET);
         remap_reg <= 2'h0;
         sramc_reg <= NUM_BLK;
      end else if (!busy && boot_done_reg) begin
         instr_tight_mem_reg  <= tcm_blocks(instr_tight_mem_size_i);
         data_tight_mem_reg  <= tcm_blocks(data_tight_mem_size_i);
         remap_reg <= remap_bit_i;
         sramc_reg <= NUM_BLK - {1'b0, tcm_blocks(instr_tight_mem_size_i)} - {1'b0, tcm_blocks(data_tight_mem_size_i)};
      end
   end
   assign sramc_blk_o = sramc_reg;

   mxdec_cfg_if cfg_if();
   assign cfg_if.instr_tight_mem_blk = instr_tight_mem_reg;
   assign cfg_if.data_tight_mem_blk = data_tight_mem_reg;
   assign cfg_if.remap    = remap_reg;
   assign cfg_if.boot     = boot_reg;

   // ==========================================================
   // one decoder per master
   logic [NUM_MST-1:0][2:0] dslave;
   logic [NUM_MST-1:0][2:0] dcs;
   logic [NUM_MST-1:0][3:0] dblk;
   logic [NUM_MST-1:0]      dabort;
   for (genvar m = 0; m < NUM_MST; m++) begin : g_dec
      mxdec_master #(.MST(m)) u_dec (
         .cfg     (cfg_if.dec),
         .addr_i  (addr_i[m]),
         .slave_o (dslave[m]),
         .cs_o    (dcs[m]),
         .blk_o   (dblk[m]),
         .abort_o (dabort[m])
      );
   end

   // ==========================================================
   // per-master abort response
   for (genvar m = 0; m < NUM_MST; m++) begin : g_err
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            st_reg[m] <= MXDEC_IDLE;
         end else begin
            case (st_reg[m])
               MXDEC_IDLE: if (req_i[m] && dabort[m]) st_reg[m] <= MXDEC_ERR1;
               MXDEC_ERR1: st_reg[m] <= MXDEC_ERR2;
               MXDEC_ERR2: st_reg[m] <= MXDEC_IDLE;
               default:    st_reg[m] <= MXDEC_IDLE;
            endcase
         end
      end
      // both error states carry bit 0, so the output is the flop itself
      assign err_o[m] = st_reg[m][0];

      sequence s_err_pair;
         err_o[m] ##1 err_o[m] ##1 !err_o[m];
      endsequence
      a_abort_err_pair: assert property (req_i[m] && dabort[m] && st_reg[m] == MXDEC_IDLE |=> s_err_pair)
         else $error("abort not answered by a two-cycle error");
      a_abort_no_ack: assert property (err_o[m] |-> !ack_o[m])
         else $error("aborted access acknowledged");
   end

   // ==========================================================
   // one arbiter per slave
   function automatic logic [NUM_MST-1:0] pick(input logic [NUM_MST-1:0] rq, input logic [2:0] last,
                                               input logic fixed);
      logic [NUM_MST-1:0] g;
      int                 j;
      g = '0;
      for (int k = 1; k <= NUM_MST; k++) begin
         j = fixed ? (k - 1) : ((int'(last) + k) % NUM_MST);
         if (rq[j] && g == '0) g[j] = 1'b1;
      end
      return g;
   endfunction

   // round robin resumes after the master served last
   logic [NUM_SLV-1:0][NUM_MST-1:0] gnt_next;
   for (genvar s = 0; s < NUM_SLV; s++) begin : g_arb
      logic [NUM_MST-1:0] rq;
      logic [2:0]         last_reg;
      always_comb begin
         for (int m = 0; m < NUM_MST; m++) begin
            rq[m] = req_i[m] && !dabort[m] && st_reg[m] == MXDEC_IDLE && dslave[m] == 3'(s);
         end
      end
      assign gnt_next[s] = pick(rq, last_reg, arb_fixed_i[s]);
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) begin
            last_reg <= 3'(NUM_MST - 1);
         end else begin
            for (int m = 0; m < NUM_MST; m++) begin
               if (gnt_next[s][m]) last_reg <= 3'(m);
            end
         end
      end
      always_ff @(posedge clk_i or negedge rstn_i) begin
         if (!rstn_i) grant_o[s] <= '0;
         else         grant_o[s] <= gnt_next[s];
      end
      a_grant_single: assert property ($onehot0(grant_o[s]))
         else $error("slave granted to more than one master");
   end

   // ==========================================================
   // master answers and slave-side selects
   logic [NUM_MST-1:0]       ack_next;
   logic [7:0]               cs_next;
   logic [3:0]               blk_next;
   logic [BLK_OFF_W-1:0]     off_next;
   always_comb begin
      ack_next = '0;
      cs_next  = 8'h00;
      blk_next = sram_blk_o;
      off_next = sram_off_o;
      for (int m = 0; m < NUM_MST; m++) begin
         for (int s = 0; s < NUM_SLV; s++) begin
            if (gnt_next[s][m]) ack_next[m] = 1'b1;
         end
         // chip select lives one cycle with its grant, never held; sram block and offset keep their last value
         if (gnt_next[SLV_EXT][m]) cs_next = 8'h01 << dcs[m];
         if (gnt_next[SLV_SRAM][m]) begin
            blk_next = dblk[m];
            off_next = addr_i[m][BLK_OFF_W-1:0];
         end
      end
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_o      <= '0;
         ext_cs_o   <= 8'h00;
         sram_blk_o <= 4'h0;
         sram_off_o <= '0;
      end else begin
         ack_o      <= ack_next;
         ext_cs_o   <= cs_next;
         sram_blk_o <= blk_next;
         sram_off_o <= off_next;
      end
   end
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         slave_o <= {NUM_MST{SLV_NONE}};
      end else begin
         for (int m = 0; m < NUM_MST; m++) begin
            slave_o[m] <= ack_next[m] ? dslave[m] : SLV_NONE;
         end
      end
   end

   // ==========================================================
   // checks
   a_ext_area_cs: assert property (req_i[2] && addr_i[2][31:28] inside {[4'h1:4'h8]} && gnt_next[SLV_EXT][2]
                                   |=> ack_o[2] && ext_cs_o == (8'h01 << ($past(addr_i[2][31:28]) - 4'h1)))
      else $error("external area did not raise its chip select");
   a_periph_area: assert property (addr_i[2][31:28] == 4'hF |-> dslave[2] == SLV_PERIPH && !dabort[2])
      else $error("area 15 not sent to peripherals");
   a_unused_area: assert property (addr_i[2][31:28] inside {4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE} |-> dabort[2])
      else $error("unused area not aborted");
   a_remap_alias: assert property (remap_reg[0] && addr_i[0][31:20] == 12'h000 && addr_i[0][19:14] == 6'h00
                                   |-> dslave[0] == SLV_SRAM && dblk[0] == NUM_BLK - 4'h1)
      else $error("remapped zero not in sram c");
   a_remap_cpu_only: assert property (remap_reg != 2'b00 && addr_i[2][31:20] == 12'h000
                                      |-> dslave[2] != SLV_SRAM)
      else $error("non-cpu master saw the remap alias");
   a_cfg_stable: assert property (busy |=> $stable(instr_tight_mem_reg) && $stable(data_tight_mem_reg) && $stable(remap_reg))
      else $error("split setting changed during a transfer");
   a_reset_split: assert property (!boot_done_reg |-> instr_tight_mem_reg == 3'h0 && data_tight_mem_reg == 3'h0 && sramc_reg == 4'hA)
      else $error("sram not all in region c after reset");
   a_boot_held: assert property (boot_done_reg |=> $stable(boot_reg) && boot_done_reg)
      else $error("boot select changed after capture");
   a_perm_c: assert property (sramc_reg >= PERM_C_BLK)
      else $error("fewer than two blocks left in sram c");

   // ==========================================================
   // decode and select checks
   a_cs_onehot: assert property ($onehot0(ext_cs_o))
      else $error("more than one chip select");
   a_cs_grant: assert property ((ext_cs_o != 8'h00) == (grant_o[SLV_EXT] != '0))
      else $error("chip select without external grant");
   a_blk_range: assert property (sram_blk_o < NUM_BLK)
      else $error("sram block out of range");
   a_rom_base: assert property (addr_i[2][31:15] == 17'h0_0080 |-> dslave[2] == SLV_ROM && !dabort[2])
      else $error("rom not at its own base");
   a_instr_tight_mem_alias: assert property (addr_i[4][31:20] == 12'h001 && addr_i[4][19:14] < {3'h0, instr_tight_mem_reg}
                                  |-> dslave[4] == SLV_SRAM && dblk[4] == INSTR_TIGHT_MEM_TOP - addr_i[4][17:14])
      else $error("instruction tcm not reachable");
   a_data_tight_mem_alias: assert property (addr_i[2][31:20] == 12'h002 && addr_i[2][19:14] < {3'h0, data_tight_mem_reg}
                                  |-> dslave[2] == SLV_SRAM && dblk[2] == DATA_TIGHT_MEM_TOP - addr_i[2][17:14])
      else $error("data tcm not reachable");
   a_sramc_base: assert property (addr_i[3][31:20] == 12'h003 && addr_i[3][19:14] < {2'h0, sramc_reg}
                                  |-> dslave[3] == SLV_SRAM)
      else $error("sram c not at its base");
   a_boot_ext: assert property (boot_done_reg && !boot_reg && !remap_reg[0] && addr_i[0][31:20] == 12'h000
                                |-> dslave[0] == SLV_EXT && dcs[0] == 3'h0)
      else $error("external boot not on chip select zero");
   a_idle_slave: assert property (!ack_o[0] |-> slave_o[0] == SLV_NONE)
      else $error("slave shown without a transfer");
endmodule
`default_nettype wire

// file: sim/mxdec_mst_model.sv
// behavioural bus masters that hold each request until it is answered
`timescale 1ns/10ps
`default_nettype none
module mxdec_mst_model import mxdec_pkg::*; (
   // clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rstn_i,
   // commands from the bench
   input  wire logic [NUM_MST-1:0]       go_i,
   input  wire logic [NUM_MST-1:0][31:0] go_addr_i,
   // answers from the matrix
   input  wire logic [NUM_MST-1:0]       ack_i,
   input  wire logic [NUM_MST-1:0]       err_i,
   // requests to the matrix
   output logic [NUM_MST-1:0]            req_o,
   output logic [NUM_MST-1:0][31:0]      addr_o
);
   // ==========================================================
   // pending request per master
   logic [NUM_MST-1:0]       pend_reg;
   logic [NUM_MST-1:0][31:0] addr_reg;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         pend_reg <= '0;
         addr_reg <= '0;
      end else begin
         pend_reg <= (pend_reg & ~(ack_i | err_i)) | go_i;
         for (int m = 0; m < NUM_MST; m++) begin
            if (go_i[m]) begin
               addr_reg[m] <= go_addr_i[m];
            end
         end
      end
   end
   // ==========================================================
   // drop at once on an answer, else the held request is taken again
   always_comb begin
      for (int m = 0; m < NUM_MST; m++) begin
         req_o[m]  = pend_reg[m] & ~ack_i[m] & ~err_i[m];
         addr_o[m] = pend_reg[m] ? addr_reg[m] : ~addr_reg[m];
      end
   end
endmodule
`default_nettype wire

// file: sim/mxdec_top_bench.sv
// self-checking bench for the bus matrix address decoder
`timescale 1ns/10ps
`default_nettype none
module mxdec_top_bench import mxdec_pkg::*; ;
   // ==========================================================
   // signals
   logic                            clk_i;
   logic                            rstn_i;
   logic                            boot_select_i;
   logic [1:0]                      instr_tight_mem_size_i;
   logic [1:0]                      data_tight_mem_size_i;
   logic [1:0]                      remap_bit_i;
   logic [NUM_SLV-1:0]              arb_fixed_i;
   logic [NUM_MST-1:0]              req_i;
   logic [NUM_MST-1:0]              ack_o;
   logic [NUM_MST-1:0]              err_o;
   logic [NUM_MST-1:0]              go;
   logic [NUM_MST-1:0][31:0]        addr_i;
   logic [NUM_MST-1:0][31:0]        go_addr;
   logic [NUM_MST-1:0][2:0]         slave_o;
   logic [NUM_SLV-1:0][NUM_MST-1:0] grant_o;
   logic [7:0]                      ext_cs_o;
   logic [3:0]                      sram_blk_o;
   logic [3:0]                      sramc_blk_o;
   logic [BLK_OFF_W-1:0]            sram_off_o;
   logic                            boot_sel_o;
   logic [3:0]                      ar;
   logic [2:0]                      es;
   logic [7:0]                      ecs;
   logic [1:0]                      it;
   logic [1:0]                      dt;
   int                              nb;
   int                              miscompares;
   int                              total_checks;

   mxdec_top dut (.clk_i(clk_i), .rstn_i(rstn_i), .boot_select_i(boot_select_i), .instr_tight_mem_size_i(instr_tight_mem_size_i),
      .data_tight_mem_size_i(data_tight_mem_size_i), .remap_bit_i(remap_bit_i), .arb_fixed_i(arb_fixed_i), .req_i(req_i),
      .addr_i(addr_i), .ack_o(ack_o), .err_o(err_o), .slave_o(slave_o), .grant_o(grant_o),
      .ext_cs_o(ext_cs_o), .sram_blk_o(sram_blk_o), .sram_off_o(sram_off_o), .boot_sel_o(boot_sel_o),
      .sramc_blk_o(sramc_blk_o));
   mxdec_mst_model masters (.clk_i(clk_i), .rstn_i(rstn_i), .go_i(go), .go_addr_i(go_addr),
      .ack_i(ack_o), .err_i(err_o), .req_o(req_i), .addr_o(addr_i));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   // ==========================================================
   // tasks
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("BAD at %0t: %s", $time, msg);
      end
   endtask
   // bounded wait, losers of arbitration may wait a few cycles
   task automatic wait_ans(input int m);
      int n;
      n = 0;
      while (ack_o[m] !== 1'b1 && err_o[m] !== 1'b1) begin
         n++;
         if (n > 50) begin
            miscompares++;
            $display("BAD at %0t: no answer", $time);
            complete_run();
         end
         @(negedge clk_i);
      end
   endtask
   // one transfer; SLV_NONE as expected slave means an abort
   task automatic run(input int m, input logic [31:0] a, input logic [2:0] s, input logic [7:0] cs,
                      input logic [3:0] b);
      @(negedge clk_i);
      go[m] = 1'b1;
      go_addr[m] = a;
      @(negedge clk_i);
      go[m] = 1'b0;
      wait_ans(m);
      if (s == SLV_NONE) begin
         chk(err_o[m] === 1'b1 && grant_o === '0 && ext_cs_o === 8'h00, "abort expected");
         @(negedge clk_i);
         chk(err_o[m] === 1'b1 && ack_o[m] === 1'b0, "error second cycle");
         @(negedge clk_i);
         chk(err_o[m] === 1'b0, "error longer than two cycles");
      end else begin
         chk(ack_o[m] === 1'b1 && slave_o[m] === s, "wrong slave");
         chk(grant_o[s][m] === 1'b1 && ext_cs_o === cs, "wrong grant or chip select");
         if (s == SLV_SRAM) begin
            chk(sram_blk_o === b && sram_off_o === a[BLK_OFF_W-1:0], "wrong sram block");
         end
         @(negedge clk_i);
         chk(ack_o[m] === 1'b0 && slave_o[m] === SLV_NONE, "ack longer than one cycle");
      end
   endtask
   // settings only move while every master is idle
   task automatic setcfg(input logic [1:0] i, input logic [1:0] d, input logic [1:0] r);
      @(negedge clk_i);
      instr_tight_mem_size_i = i;
      data_tight_mem_size_i = d;
      remap_bit_i = r;
      repeat (3) @(negedge clk_i);
   endtask
   task automatic do_reset(input logic b);
      @(negedge clk_i);
      rstn_i = 1'b0;
      boot_select_i = b;
      repeat (16) @(negedge clk_i);
      chk(sramc_blk_o === 4'hA && ack_o === '0 && err_o === '0 && slave_o === {NUM_MST{SLV_NONE}}, "reset");
      rstn_i = 1'b1;
      repeat (5) @(negedge clk_i);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      rstn_i = 1'b0;
      boot_select_i = 1'b1;
      instr_tight_mem_size_i = 2'h0;
      data_tight_mem_size_i = 2'h0;
      remap_bit_i = 2'b00;
      arb_fixed_i = 5'h1F;
      go = '0;
      go_addr = '0;
      miscompares = 0;
      total_checks = 0;
      do_reset(1'b1);
      chk(boot_sel_o === 1'b1, "boot select capture");
      for (int a = 1; a < 16; a++) begin
         ar = 4'(a);
         es = (a <= 8) ? SLV_EXT : ((a == 15) ? SLV_PERIPH : SLV_NONE);
         ecs = (a <= 8) ? (8'h01 << (a - 1)) : 8'h00;
         run(2, {ar, 28'h000_0000}, es, ecs, 4'h0);
      end
      $display("test areas done");
      run(2, 32'h0040_0010, SLV_ROM, 8'h00, 4'h0);
      run(3, 32'h0050_0000, SLV_DISP, 8'h00, 4'h0);
      run(4, 32'h0060_0000, SLV_DISP, 8'h00, 4'h0);
      run(4, 32'h0070_0000, SLV_NONE, 8'h00, 4'h0);
      run(2, 32'h0030_0004, SLV_SRAM, 8'h00, 4'h9);
      run(3, 32'h0032_4000, SLV_SRAM, 8'h00, 4'h0);
      run(0, 32'h0000_0000, SLV_ROM, 8'h00, 4'h0);
      setcfg(2'h0, 2'h0, 2'b01);
      run(0, 32'h0000_0004, SLV_SRAM, 8'h00, 4'h9);
      run(1, 32'h0000_0004, SLV_ROM, 8'h00, 4'h0);
      run(2, 32'h0000_0000, SLV_ROM, 8'h00, 4'h0);
      run(0, 32'h0030_0000, SLV_SRAM, 8'h00, 4'h9);
      setcfg(2'h0, 2'h0, 2'b10);
      run(0, 32'h0000_0000, SLV_ROM, 8'h00, 4'h0);
      run(1, 32'h0000_0000, SLV_SRAM, 8'h00, 4'h9);
      $display("test remap done");
      for (int i = 0; i < 16; i++) begin
         it = 2'(i >> 2);
         dt = 2'(i);
         setcfg(it, dt, 2'b00);
         nb = 10 - ((it == 2'h3) ? 4 : int'(it)) - ((dt == 2'h3) ? 4 : int'(dt));
         chk(sramc_blk_o === 4'(nb), "sram c size");
      end
      setcfg(2'h3, 2'h1, 2'b00);
      run(1, 32'h0010_0000, SLV_SRAM, 8'h00, 4'h3);
      run(4, 32'h0010_C008, SLV_SRAM, 8'h00, 4'h0);
      run(2, 32'h0020_0000, SLV_SRAM, 8'h00, 4'h7);
      run(2, 32'h0020_4000, SLV_NONE, 8'h00, 4'h0);
      run(3, 32'h0030_8123, SLV_SRAM, 8'h00, 4'h6);
      run(3, 32'h0031_4000, SLV_NONE, 8'h00, 4'h0);
      setcfg(2'h3, 2'h3, 2'b00);
      run(2, 32'h0030_4000, SLV_SRAM, 8'h00, 4'h8);
      run(2, 32'h0030_8000, SLV_NONE, 8'h00, 4'h0);
      $display("test split done");
      @(negedge clk_i);
      go = 5'b00101;
      go_addr[0] = 32'h1000_0000;
      go_addr[2] = 32'h2000_0000;
      @(negedge clk_i);
      go = '0;
      wait_ans(0);
      chk(ack_o[2] === 1'b0 && grant_o[SLV_EXT] === 5'b00001, "fixed priority");
      @(negedge clk_i);
      chk(ack_o[2] === 1'b1 && ext_cs_o === 8'h02, "loser served next");
      @(negedge clk_i);
      arb_fixed_i = 5'h00;
      go = 5'b10001;
      go_addr[4] = 32'h3000_0000;
      @(negedge clk_i);
      go = '0;
      wait_ans(4);
      chk(ack_o[0] === 1'b0 && ext_cs_o === 8'h04, "round robin order");
      @(negedge clk_i);
      chk(ack_o[0] === 1'b1 && ext_cs_o === 8'h01, "round robin next");
      repeat (2) @(negedge clk_i);
      $display("test arbitration done");
      do_reset(1'b0);
      chk(boot_sel_o === 1'b0, "boot select capture");
      run(0, 32'h0000_0000, SLV_EXT, 8'h01, 4'h0);
      run(1, 32'h0040_0000, SLV_ROM, 8'h00, 4'h0);
      run(2, 32'h0030_0000, SLV_SRAM, 8'h00, 4'h9);
      $display("test external boot done");
      complete_run();
   end
endmodule
`default_nettype wire
